// ==== src/key_debounce.sv ====
`timescale 1ns/10ps
module key_debounce #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       tick_i,
  input  wire logic [7:0] interval_i,
  input  wire logic       level_i,
  output logic            level_o
);
  logic       state_q;
  logic       state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] limit;

  always_comb begin
    limit   = (interval_i == 8'h00) ? 8'h01 : interval_i;
    state_d = state_q;
    cnt_d   = cnt_q;
    if (level_i == state_q) begin
      cnt_d = 8'h00;
    end else if (tick_i) begin
      if ({1'b0, cnt_q} + 9'h001 >= {1'b0, limit}) begin
        state_d = level_i;
        cnt_d   = 8'h00;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_q <= RESET_LEVEL;
      cnt_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign level_o = state_q;

  a_change_on_tick: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $changed(level_o) |-> $past(tick_i) && level_o == $past(level_i))
    else $error("debounced level changed without a tick or against the pin");
endmodule

// ==== src/keypad_front_end.sv ====
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module keypad_front_end #(
  parameter int unsigned TICK_CYCLES = keypad_pkg::TICK_CYCLES
) (
  input  wire logic                          clock_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          hsel_i,
  input  wire logic [31:0]                   haddr_i,
  input  wire logic [1:0]                    htrans_i,
  input  wire logic                          hwrite_i,
  input  wire logic [2:0]                    hsize_i,
  input  wire logic                          hready_i,
  input  wire logic [31:0]                   hwdata_i,
  output logic      [31:0]                   hrdata_o,
  output logic                               hreadyout_o,
  output logic                               hresp_o,
  input  wire logic [keypad_pkg::NUM_KEYS-1:0] key_n_i,
  input  wire logic                          remote_a_i,
  input  wire logic                          remote_b_i,
  output logic                               mem_sclk_o,
  output logic                               mem_cs_n_o,
  output logic                               mem_sdo_o,
  input  wire logic                          mem_sdi_i,
  output logic                               irq_o
);
  localparam int unsigned NK = keypad_pkg::NUM_KEYS;
  localparam int unsigned NE = keypad_pkg::NUM_EVENTS;
  // millisecond tick divider
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic        tick_q;
  logic        tick_d;

  always_comb begin
    tick_d = 1'b0;
    div_d  = div_q + 16'h0001;
    if (div_q == 16'(TICK_CYCLES - 1)) begin
      div_d  = 16'h0000;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end
  // debounce: keys, remote lines, remote line equality, one channel each
  localparam int unsigned ND = NK + 3;
  localparam logic [ND-1:0] DB_RST = {1'b0, keypad_pkg::REMOTE_B_IDLE,
                                      keypad_pkg::REMOTE_A_IDLE, {NK{1'b0}}};
  logic [7:0]    interval_q;
  logic [7:0]    interval_d;
  logic [ND-1:0] db_in;
  logic [ND-1:0] db_out;
  logic [NK-1:0] key_state;
  logic          remote_a_db;
  logic          remote_b_db;
  logic          line_fault;
  logic          remote_pressed;
  assign db_in = {remote_a_i == remote_b_i, remote_b_i, remote_a_i, ~key_n_i};
  for (genvar g = 0; g < ND; g++) begin : g_db
    key_debounce #(.RESET_LEVEL(DB_RST[g])) u_db (
      .clock_i    (clock_i),
      .reset_n_i  (reset_n_i),
      .tick_i     (tick_q),
      .interval_i (interval_q),
      .level_i    (db_in[g]),
      .level_o    (db_out[g])
    );
  end
  assign key_state   = db_out[NK-1:0];
  assign remote_a_db = db_out[NK];
  assign remote_b_db = db_out[NK+1];
  assign line_fault  = db_out[NK+2];
  // request only when both lines have swapped away from idle
  assign remote_pressed = (remote_a_db == ~keypad_pkg::REMOTE_A_IDLE) &&
                          (remote_b_db == ~keypad_pkg::REMOTE_B_IDLE);
  // ahb-lite slave, zero wait states
  logic        addr_ok;
  logic        wr_q;
  logic        wr_d;
  logic [31:0] waddr_q;
  logic [31:0] waddr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [NE-1:0] status_q;
  logic [NE-1:0] status_d;
  logic [NE-1:0] mask_q;
  logic [NE-1:0] mask_d;
  logic [NE-1:0] events;
  logic [NK-1:0] key_prev_q;
  logic          remote_prev_q;
  logic          fault_prev_q;
  logic          mem_start;
  logic          mem_done;
  logic          mem_busy;
  logic [7:0]    rx_q;
  assign addr_ok = hsel_i && hready_i && (htrans_i == keypad_pkg::HTRANS_NONSEQ);
  always_comb begin
    wr_d    = addr_ok && hwrite_i;
    waddr_d = haddr_i;
    rdata_d = rdata_q;
    if (addr_ok && !hwrite_i) begin
      if (haddr_i == keypad_pkg::KEY_STATUS_ADDR) begin
        rdata_d = 32'({remote_pressed, key_state});
      end else if (haddr_i == keypad_pkg::EVT_STATUS_ADDR) begin
        rdata_d = 32'(status_q);
      end else if (haddr_i == keypad_pkg::EVT_MASK_ADDR) begin
        rdata_d = 32'(mask_q);
      end else if (haddr_i == keypad_pkg::DEBOUNCE_ADDR) begin
        rdata_d = 32'(interval_q);
      end else if (haddr_i == keypad_pkg::LINE_STATUS_ADDR) begin
        rdata_d = 32'({remote_b_db, remote_a_db, line_fault});
      end else if (haddr_i == keypad_pkg::MEM_XFER_ADDR) begin
        rdata_d = 32'({mem_busy, rx_q});
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end
  assign events = {mem_done,
                   line_fault && !fault_prev_q,
                   remote_pressed && !remote_prev_q,
                   key_state & ~key_prev_q};
  assign mem_start = wr_q && (waddr_q == keypad_pkg::MEM_XFER_ADDR) && !mem_busy;
  always_comb begin
    mask_d     = mask_q;
    interval_d = interval_q;
    status_d   = status_q;
    if (wr_q && waddr_q == keypad_pkg::EVT_STATUS_ADDR) begin
      status_d = status_q & ~hwdata_i[NE-1:0];
    end
    if (wr_q && waddr_q == keypad_pkg::EVT_MASK_ADDR) begin
      mask_d = hwdata_i[NE-1:0];
    end
    if (wr_q && waddr_q == keypad_pkg::DEBOUNCE_ADDR) begin
      interval_d = hwdata_i[7:0];
    end
    status_d = status_d | events;
  end
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      wr_q          <= 1'b0;
      waddr_q       <= 32'h0000_0000;
      rdata_q       <= 32'h0000_0000;
      status_q      <= '0;
      mask_q        <= keypad_pkg::MASK_RST;
      interval_q    <= keypad_pkg::DEBOUNCE_MS_RST;
      key_prev_q    <= '0;
      remote_prev_q <= 1'b0;
      fault_prev_q  <= 1'b0;
    end else begin
      wr_q          <= wr_d;
      waddr_q       <= waddr_d;
      rdata_q       <= rdata_d;
      status_q      <= status_d;
      mask_q        <= mask_d;
      interval_q    <= interval_d;
      key_prev_q    <= key_state;
      remote_prev_q <= remote_pressed;
      fault_prev_q  <= line_fault;
    end
  end
  assign hrdata_o    = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = keypad_pkg::HRESP_OKAY;
  assign irq_o       = |(status_q & mask_q);
  // serial settings-memory shifter, msb first
  keypad_pkg::ser_state_t ser_q;
  keypad_pkg::ser_state_t ser_d;
  logic [4:0] half_q;
  logic [4:0] half_d;
  logic [3:0] bits_q;
  logic [3:0] bits_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [7:0] rx_d;
  logic       sclk_q;
  logic       cs_n_q;
  always_comb begin
    ser_d    = ser_q;
    half_d   = half_q;
    bits_d   = bits_q;
    tx_d     = tx_q;
    rx_d     = rx_q;
    mem_done = 1'b0;
    case (ser_q)
      keypad_pkg::SER_IDLE: begin
        if (mem_start) begin
          tx_d   = hwdata_i[7:0];
          bits_d = 4'(keypad_pkg::MEM_BITS);
          half_d = 5'h00;
          ser_d  = keypad_pkg::SER_LOW;
        end
      end
      keypad_pkg::SER_LOW: begin
        if (half_q == 5'(keypad_pkg::SCLK_HALF - 1)) begin
          half_d = 5'h00;
          rx_d   = {rx_q[6:0], mem_sdi_i};
          ser_d  = keypad_pkg::SER_HIGH;
        end else begin
          half_d = half_q + 5'h01;
        end
      end
      default: begin
        if (half_q == 5'(keypad_pkg::SCLK_HALF - 1)) begin
          half_d = 5'h00;
          if (bits_q == 4'h1) begin
            ser_d    = keypad_pkg::SER_IDLE;
            mem_done = 1'b1;
          end else begin
            bits_d = bits_q - 4'h1;
            tx_d   = {tx_q[6:0], 1'b0};
            ser_d  = keypad_pkg::SER_LOW;
          end
        end else begin
          half_d = half_q + 5'h01;
        end
      end
    endcase
  end
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ser_q  <= keypad_pkg::SER_IDLE;
      half_q <= 5'h00;
      bits_q <= 4'h0;
      tx_q   <= 8'h00;
      rx_q   <= 8'h00;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      ser_q  <= ser_d;
      half_q <= half_d;
      bits_q <= bits_d;
      tx_q   <= tx_d;
      rx_q   <= rx_d;
      sclk_q <= (ser_d == keypad_pkg::SER_HIGH);
      cs_n_q <= (ser_d == keypad_pkg::SER_IDLE);
    end
  end
  assign mem_busy   = (ser_q != keypad_pkg::SER_IDLE);
  assign mem_sclk_o = sclk_q;
  assign mem_cs_n_o = cs_n_q;
  assign mem_sdo_o  = tx_q[7];
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic [3:0] edge_cnt_q;
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || mem_cs_n_o) begin
      edge_cnt_q <= 4'h0;
    end else if (sclk_q && !$past(sclk_q)) begin
      edge_cnt_q <= edge_cnt_q + 4'h1;
    end
  end
  a_key_active_low: assert property ($rose(key_state[0]) |-> $past(key_n_i[0]) == 1'b0)
    else $error("key reported pressed while its pin was high");
  a_key_held: assert property (key_state[0] && !key_n_i[0] |=> key_state[0])
    else $error("pressed key dropped while still closed");
  a_key_read: assert property (addr_ok && !hwrite_i && haddr_i == keypad_pkg::KEY_STATUS_ADDR
    |=> hrdata_o[NK-1:0] == $past(key_state) && hrdata_o[31:10] == 22'h000000)
    else $error("key status read returned wrong data");
  a_nine_keys: assert property ($rose(|key_state) |=> status_q[NK-1:0] != '0)
    else $error("key press did not set an event bit");
  a_remote_both: assert property ($rose(remote_pressed)
    |-> $past(remote_a_i) == ~keypad_pkg::REMOTE_A_IDLE
     && $past(remote_b_i) == ~keypad_pkg::REMOTE_B_IDLE)
    else $error("remote request without both lines swapped");
  a_remote_event: assert property ($rose(remote_pressed) |=> status_q[keypad_pkg::EVT_REMOTE_BIT])
    else $error("remote request event not latched");
  a_line_fault: assert property ($rose(line_fault)
    |-> $past(remote_a_i == remote_b_i) ##1 status_q[keypad_pkg::EVT_FAULT_BIT])
    else $error("line fault flag wrong");
  a_debounce_cfg: assert property (wr_q && waddr_q == keypad_pkg::DEBOUNCE_ADDR
    |=> interval_q == $past(hwdata_i[7:0]))
    else $error("debounce interval not written");
  a_serial_bits: assert property ($rose(mem_cs_n_o) |-> $past(edge_cnt_q) == 4'h8)
    else $error("serial frame did not carry eight clocks");
  a_serial_idle: assert property (mem_cs_n_o |-> !mem_sclk_o)
    else $error("serial clock active while deselected");
  c_key_press: cover property ($rose(key_state[0]));
  c_remote_req: cover property ($rose(remote_pressed));
  c_line_fault: cover property ($rose(line_fault));
  c_mem_done: cover property (mem_done ##1 irq_o);
endmodule

// ==== src/keypad_pkg.sv ====
package keypad_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYCLES    = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SCLK_PERIOD_NS = 1000;
  localparam int unsigned SCLK_HALF      = (SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS;

  localparam int unsigned NUM_KEYS   = 9;
  localparam int unsigned MEM_BITS   = 8;
  localparam int unsigned NUM_EVENTS = 12;

  localparam logic [31:0] KEY_STATUS_ADDR  = 32'h0000_0000;
  localparam logic [31:0] EVT_STATUS_ADDR  = 32'h0000_0004;
  localparam logic [31:0] EVT_MASK_ADDR    = 32'h0000_0008;
  localparam logic [31:0] DEBOUNCE_ADDR    = 32'h0000_000c;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h0000_0010;
  localparam logic [31:0] MEM_XFER_ADDR    = 32'h0000_0014;

  localparam int unsigned KEY_REMOTE_BIT = 9;
  localparam int unsigned EVT_REMOTE_BIT = 9;
  localparam int unsigned EVT_FAULT_BIT  = 10;
  localparam int unsigned EVT_MEM_BIT    = 11;
  localparam int unsigned MEM_BUSY_BIT   = 8;

  localparam logic [7:0] DEBOUNCE_MS_RST = 8'h08;
  localparam logic [NUM_EVENTS-1:0] MASK_RST = 12'h000;
  localparam logic REMOTE_A_IDLE = 1'b1;
  localparam logic REMOTE_B_IDLE = 1'b0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {SER_IDLE, SER_LOW, SER_HIGH} ser_state_t;
endpackage

// ==== tb/keypad_front_end_tb.sv ====
`timescale 1ns/10ps
module keypad_front_end_tb;
  logic        clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [8:0]  press = 9'h0;
  logic        rpress = 1'b0;
  logic        lbreak = 1'b0;
  logic [8:0]  key_n;
  logic        ra, rb, sclk, cs_n, sdo, sdi, irq;
  logic [7:0]  got;
  logic [31:0] r;
  int          err_total = 0;
  int          checked = 0;

  always #12.5 clock_i = ~clock_i;

  keypad_front_end #(.TICK_CYCLES(8)) u_dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .key_n_i(key_n), .remote_a_i(ra), .remote_b_i(rb), .mem_sclk_o(sclk),
    .mem_cs_n_o(cs_n), .mem_sdo_o(sdo), .mem_sdi_i(sdi), .irq_o(irq));

  keypad_partner u_partner (
    .clock_i(clock_i), .press_i(press), .remote_press_i(rpress),
    .line_break_i(lbreak), .mem_sclk_i(sclk), .mem_cs_n_i(cs_n), .mem_sdo_i(sdo),
    .key_n_o(key_n), .remote_a_o(ra), .remote_b_o(rb), .mem_sdi_o(sdi), .got_o(got));

  task automatic close_out();
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clock_i);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clock_i);
  endtask

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clock_i);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= keypad_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clock_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_i); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, keypad_pkg::HRESP_OKAY});
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] t;
    xfer(a, 1'b1, d, t);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] t;
    xfer(a, 1'b0, 32'h0, t);
    chk(t, e);
  endtask

  task automatic settle();
    repeat (40) @(posedge clock_i);
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    rd_chk(keypad_pkg::DEBOUNCE_ADDR, 32'h8);
    rd_chk(keypad_pkg::EVT_MASK_ADDR, 32'h0);
    rd_chk(keypad_pkg::KEY_STATUS_ADDR, 32'h0);
    rd_chk(32'h0000_0040, 32'h0);
    wr(keypad_pkg::DEBOUNCE_ADDR, 32'h2);
    wr(keypad_pkg::EVT_MASK_ADDR, 32'hfff);
    rd_chk(keypad_pkg::EVT_MASK_ADDR, 32'hfff);
    for (int i = 0; i < 9; i++) begin
      press[i] <= 1'b1;
      settle();
      rd_chk(keypad_pkg::KEY_STATUS_ADDR, 32'h1 << i);
      rd_chk(keypad_pkg::EVT_STATUS_ADDR, 32'h1 << i);
      chk_irq(1'b1);
      wr(keypad_pkg::EVT_STATUS_ADDR, 32'hfff);
      chk_irq(1'b0);
      rd_chk(keypad_pkg::KEY_STATUS_ADDR, 32'h1 << i);
      press[i] <= 1'b0;
      settle();
      rd_chk(keypad_pkg::KEY_STATUS_ADDR, 32'h0);
    end
    // bounce shorter than the interval is ignored
    press[4] <= 1'b1;
    repeat (3) @(posedge clock_i);
    press[4] <= 1'b0;
    settle();
    rd_chk(keypad_pkg::KEY_STATUS_ADDR, 32'h0);
    rd_chk(keypad_pkg::EVT_STATUS_ADDR, 32'h0);
    // one broken line: fault, no request
    lbreak <= 1'b1;
    settle();
    rd_chk(keypad_pkg::KEY_STATUS_ADDR, 32'h0);
    rd_chk(keypad_pkg::LINE_STATUS_ADDR, 32'h1);
    rd_chk(keypad_pkg::EVT_STATUS_ADDR, 32'h400);
    lbreak <= 1'b0;
    settle();
    wr(keypad_pkg::EVT_STATUS_ADDR, 32'hfff);
    rd_chk(keypad_pkg::LINE_STATUS_ADDR, 32'h2);
    // both lines swapped: request, but masked
    wr(keypad_pkg::EVT_MASK_ADDR, 32'h0);
    rpress <= 1'b1;
    settle();
    rd_chk(keypad_pkg::KEY_STATUS_ADDR, 32'h200);
    rd_chk(keypad_pkg::LINE_STATUS_ADDR, 32'h4);
    rd_chk(keypad_pkg::EVT_STATUS_ADDR, 32'h200);
    chk_irq(1'b0);
    rpress <= 1'b0;
    settle();
    wr(keypad_pkg::EVT_STATUS_ADDR, 32'hfff);
    wr(keypad_pkg::EVT_MASK_ADDR, 32'h800);
    // serial transfer, second start while busy is dropped
    wr(keypad_pkg::MEM_XFER_ADDR, 32'ha5);
    wr(keypad_pkg::MEM_XFER_ADDR, 32'hff);
    xfer(keypad_pkg::MEM_XFER_ADDR, 1'b0, 32'h0, r);
    chk(r & 32'h100, 32'h100);
    for (int k = 0; k < 200 && r[8] !== 1'b0; k++) begin
      xfer(keypad_pkg::MEM_XFER_ADDR, 1'b0, 32'h0, r);
    end
    chk(r, 32'h3c);
    chk({24'h0, got}, 32'ha5);
    chk_irq(1'b1);
    rd_chk(keypad_pkg::EVT_STATUS_ADDR, 32'h800);
    settle();
    chk({24'h0, got}, 32'ha5);
    close_out();
  end
endmodule

// ==== tb/keypad_partner.sv ====
`timescale 1ns/10ps
module keypad_partner (
  input  wire logic       clock_i,
  input  wire logic [8:0] press_i,
  input  wire logic       remote_press_i,
  input  wire logic       line_break_i,
  input  wire logic       mem_sclk_i,
  input  wire logic       mem_cs_n_i,
  input  wire logic       mem_sdo_i,
  output logic      [8:0] key_n_o,
  output logic            remote_a_o,
  output logic            remote_b_o,
  output logic            mem_sdi_o,
  output logic      [7:0] got_o
);
  localparam logic [7:0] RESP = 8'h3c;
  logic       sclk_q = 1'b0;
  logic [2:0] idx_q  = 3'h7;
  logic [7:0] got_q  = 8'h00;
  // closed switch grounds its pin
  assign key_n_o    = ~press_i;
  // idle lines opposite, press swaps both; break flips one line only
  assign remote_a_o = ~remote_press_i ^ line_break_i;
  assign remote_b_o = remote_press_i;
  // deselected memory drives the inverse of its last bit
  assign mem_sdi_o  = mem_cs_n_i ? ~RESP[0] : RESP[idx_q];
  assign got_o = got_q;
  always @(posedge clock_i) begin
    sclk_q <= mem_sclk_i;
    if (mem_cs_n_i) begin
      idx_q <= 3'h7;
    end else if (sclk_q && !mem_sclk_i) begin
      idx_q <= idx_q - 3'h1;
    end
    if (!sclk_q && mem_sclk_i) begin
      got_q <= {got_q[6:0], mem_sdo_i};
    end
  end
endmodule
